//--- design/psw_sleep_wake.sv
/*
  Sleep / wake-up sequencer for a loop-regulated pump drive: sleep and
  wake condition evaluation, delay qualification, boost run, register port.
  Assumes process values arrive already scaled on core_clk; digital switch
  pins are asynchronous and are synchronised here.
*/
// How it works
// - sleep only after qualified sleep condition outlasts sleep delay, no wake condition
// - flow mode: sleep when flow value below sleep level
// - switch mode: sleep when assigned switch input active
// - speed mode: sleep when output frequency below sleep speed
// - power mode: sleep when output power below sleep power
// - pressure mode: sleep when pressure above sleep level
// - multiple mode: OR of all configured conditions
// - seven detection modes, reset to none which disables sleep
// - wake only after wake condition outlasts wake delay
// - feedback wake, direct: feedback below wake level
// - feedback wake, inverted: feedback above wake level
// - error wake, direct: feedback below setpoint minus wake error
// - error wake, inverted: feedback above setpoint plus wake error
// - pressure wake: pressure below wake level
// - on sleep entry boost for boost time, then stop
// - zero boost time skips boost
// - acts only with loop configured, channel one and automatic
// - run order in automatic: wake condition starts loop, else sleep unboosted
// - entering automatic while running goes straight to regulation
// - switch source none, pin, inverted pin or command bit; switch/multiple only
// - sensor source none, analog, virtual analog or pulse
// - settings locked and function idle without feedback source
`timescale 1ns/1ps
module psw_sleep_wake
  import psw_pkg::*;
#(
  parameter int NDI = 6
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // drive state
  input wire logic chan1_sel,
  input wire logic pid_auto,
  input wire logic run_order,
  input wire logic motor_running,
  // process values
  input wire logic [DW-1:0] out_freq,
  input wire logic [DW-1:0] out_power,
  input wire logic signed [DW-1:0] loop_feedback,
  input wire logic signed [DW-1:0] loop_setpoint,
  input wire psw_sens_t sens,
  // switch pins
  input wire logic [NDI-1:0] din_pins,
  // motor commands
  output psw_motor_t motor_cmd,
  output logic [DW-1:0] speed_ref
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the switch index field reaches sixteen pins at most
  if (NDI < 1 || NDI > 16) begin : g_bad_ndi
    $error("NDI must lie between 1 and 16");
  end
  // the control word is overlaid on one register
  if ($bits(psw_ctrl_t) != DW) begin : g_bad_ctrl
    $error("control struct must fill one register word");
  end
  // every stored register needs an index on the port
  if (N_CFG > (1 << AW)) begin : g_bad_map
    $error("register map exceeds the address range");
  end

  typedef enum logic [1:0] {st_idle, st_run, st_boost, st_sleep} psw_st_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [DW-1:0] cfg_r [N_CFG];
  logic [DW-1:0] rdata_r;
  logic [NDI-1:0] din_m_r;
  logic [NDI-1:0] din_s_r;
  psw_st_t st_r;
  psw_st_t st_nxt;
  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;
  psw_motor_t cmd_r;
  logic [DW-1:0] spd_r;
  psw_ctrl_t ctrl;
  logic fb_ok;
  logic pid_mode;
  logic [15:0] din_w;
  logic [SWSEL_IDX_W-1:0] sw_idx;
  logic sw_raw;
  logic sw_ok;
  logic c_sw;
  logic c_flow;
  logic c_speed;
  logic c_power;
  logic c_hp;
  logic sleep_c;
  logic wake_c;
  logic slp_q;
  logic signed [DW-1:0] flow_v;
  logic signed [DW-1:0] pres_v;
  logic signed [DW:0] fb_x;
  logic signed [DW:0] err_lo;
  logic signed [DW:0] err_hi;
  logic [DW:0] boost_end;
  logic [DW-1:0] rd_val;
  logic [DW-1:0] status_w;
  logic wr_ok;

  // ----------------------------------------------------------------
  // sensor source selection
  // ----------------------------------------------------------------
  function automatic logic signed [DW-1:0] pick(
    input psw_src_t s,
    input psw_sens_t v
  );
    case (s)
      src_ai: pick = v.ai;
      src_vai: pick = v.vai;
      src_pulse: pick = v.pulse;
      default: pick = '0;
    endcase
  endfunction

  assign ctrl = psw_ctrl_t'(cfg_r[A_CTRL]);
  assign fb_ok = ctrl.loop_feedback_source != src_none;
  assign pid_mode = fb_ok && chan1_sel && pid_auto && run_order;
  assign flow_v = pick(ctrl.flow_sensor_source, sens);
  assign pres_v = pick(ctrl.pressure_sensor_source, sens);

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // with no feedback source only the control word is reachable
  // status and counter words are hidden as well
  assign wr_ok = reg_wr && (int'(reg_addr) < N_CFG) && (reg_addr == A_CTRL || fb_ok);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < N_CFG; i++) begin
        cfg_r[i] <= RST_CFG;
      end
    end else if (clk_en && wr_ok) begin
      cfg_r[reg_addr] <= reg_wdata;
    end
  end

  // status word: state, qualified conditions and raw sleep terms
  assign status_w = {7'h00, c_hp, c_power, c_speed, c_flow, c_sw,
                     wake_c, sleep_c, 2'(st_r)};

  always_comb begin
    rd_val = RD_ZERO;
    if (reg_addr == A_CTRL) begin
      rd_val = cfg_r[A_CTRL];
    end else if (!fb_ok) begin
      rd_val = RD_ZERO;
    end else if (int'(reg_addr) < N_CFG) begin
      rd_val = cfg_r[reg_addr];
    end else if (reg_addr == A_STATUS) begin
      rd_val = status_w;
    end else if (reg_addr == A_COUNT) begin
      rd_val = cnt_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_r <= RD_ZERO;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rd_val : RD_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // switch pin synchroniser
  // ----------------------------------------------------------------
  // only the second stage feeds logic; the first may be metastable
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      din_m_r <= '0;
      din_s_r <= '0;
    end else if (clk_en) begin
      din_m_r <= din_pins;
      din_s_r <= din_m_r;
    end
  end

  // ----------------------------------------------------------------
  // sleep conditions
  // ----------------------------------------------------------------
  assign din_w = 16'(din_s_r);
  assign sw_idx = cfg_r[A_SWSEL][SWSEL_IDX_LSB +: SWSEL_IDX_W];

  always_comb begin
    case (ctrl.sw_kind)
      swk_di: sw_raw = din_w[sw_idx];
      swk_di_low: sw_raw = ~din_w[sw_idx];
      swk_cmd: sw_raw = cfg_r[A_CMD][sw_idx];
      default: sw_raw = 1'b0;
    endcase
  end

  assign sw_ok = ctrl.det_mode == det_switch || ctrl.det_mode == det_multiple;
  assign c_sw = sw_ok && sw_raw;
  assign c_flow = ctrl.flow_sensor_source != src_none &&
                  flow_v < $signed(cfg_r[A_SLP_FLOW]);
  // an unset speed or power level of zero can never trip
  assign c_speed = out_freq < cfg_r[A_SLP_SPEED];
  assign c_power = out_power < cfg_r[A_SLP_POWER];
  assign c_hp = ctrl.pressure_sensor_source != src_none &&
                pres_v > $signed(cfg_r[A_SLP_PRES]);

  always_comb begin
    case (ctrl.det_mode)
      det_switch: sleep_c = c_sw;
      low_flow_code: sleep_c = c_flow;
      speed_condition_code: sleep_c = c_speed;
      power_condition_code: sleep_c = c_power;
      high_pressure_code: sleep_c = c_hp;
      det_multiple: sleep_c = c_sw | c_flow | c_speed | c_power | c_hp;
      default: sleep_c = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // wake conditions
  // ----------------------------------------------------------------
  // one extra bit keeps setpoint plus or minus a wake error of at most 32768 from wrapping
  assign fb_x = {loop_feedback[DW-1], loop_feedback};
  assign err_lo = {loop_setpoint[DW-1], loop_setpoint} - $signed({1'b0, cfg_r[A_WAKE_ERR]});
  assign err_hi = {loop_setpoint[DW-1], loop_setpoint} + $signed({1'b0, cfg_r[A_WAKE_ERR]});

  always_comb begin
    case (ctrl.wake_mode)
      wake_feedback: begin
        if (ctrl.loop_action_invert) begin
          wake_c = loop_feedback > $signed(cfg_r[A_WAKE_LVL]);
        end else begin
          wake_c = loop_feedback < $signed(cfg_r[A_WAKE_LVL]);
        end
      end
      wake_error: begin
        if (ctrl.loop_action_invert) begin
          wake_c = fb_x > err_hi;
        end else begin
          wake_c = fb_x < err_lo;
        end
      end
      wake_pressure: begin
        wake_c = ctrl.pressure_sensor_source != src_none &&
                 pres_v < $signed(cfg_r[A_WAKE_LVL]);
      end
      default: wake_c = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign slp_q = sleep_c && !wake_c;
  assign boost_end = {1'b0, cnt_r} + 17'h00001;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      st_idle: begin
        // entry decision made once, on the first edge in loop mode
        if (pid_mode) begin
          if (motor_running) begin
            st_nxt = st_run;
          end else begin
            st_nxt = wake_c ? st_run : st_sleep;
          end
        end
      end
      st_run: begin
        if (!pid_mode) begin
          st_nxt = st_idle;
        end else if (slp_q && cnt_r >= cfg_r[A_SLP_DLY]) begin
          if (cfg_r[A_BOOST_TIME] == RST_CFG) begin
            st_nxt = st_sleep;
          end else begin
            st_nxt = st_boost;
          end
        end
      end
      st_boost: begin
        // wake is ignored here; the boost run completes unless loop mode drops
        if (!pid_mode) begin
          st_nxt = st_idle;
        end else if (boost_end >= {1'b0, cfg_r[A_BOOST_TIME]}) begin
          st_nxt = st_sleep;
        end
      end
      st_sleep: begin
        if (!pid_mode) begin
          st_nxt = st_idle;
        end else if (wake_c && cnt_r >= cfg_r[A_WAKE_DLY]) begin
          st_nxt = st_run;
        end
      end
      default: st_nxt = st_idle;
    endcase
  end

  // counter holds cycles the watched condition has held so far
  always_comb begin
    cnt_nxt = '0;
    if (st_nxt == st_r) begin
      case (st_r)
        st_run: cnt_nxt = slp_q ? boost_end[DW-1:0] : '0;
        st_boost: cnt_nxt = boost_end[DW-1:0];
        st_sleep: cnt_nxt = wake_c ? boost_end[DW-1:0] : '0;
        default: cnt_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= st_idle;
      cnt_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // motor command outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd_r <= '0;
    end else if (clk_en) begin
      cmd_r.active <= st_nxt != st_idle;
      cmd_r.pid_run <= st_nxt == st_run;
      cmd_r.boost_on <= st_nxt == st_boost;
      cmd_r.motor_stop <= st_nxt == st_sleep;
      cmd_r.asleep <= st_nxt == st_boost || st_nxt == st_sleep;
    end
  end

  // speed reference kept apart: only the boost run drives it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      spd_r <= '0;
    end else if (clk_en) begin
      spd_r <= (st_nxt == st_boost) ? cfg_r[A_BOOST_SPD] : '0;
    end
  end

  assign motor_cmd = cmd_r;
  assign speed_ref = spd_r;

endmodule

//--- design/psw_pkg.sv
/*
  Shared constants and types for the pump sleep / wake-up controller:
  register indices, reset values, mode encodings and carrier structs.
  Assumes a 16-bit register port addressed by word index.
*/
package psw_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DW = 16;
  localparam int AW = 4;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] A_CTRL = 4'h0;
  localparam logic [AW-1:0] A_SWSEL = 4'h1;
  localparam logic [AW-1:0] A_CMD = 4'h2;
  localparam logic [AW-1:0] A_SLP_FLOW = 4'h3;
  localparam logic [AW-1:0] A_SLP_PRES = 4'h4;
  localparam logic [AW-1:0] A_SLP_SPEED = 4'h5;
  localparam logic [AW-1:0] A_SLP_POWER = 4'h6;
  localparam logic [AW-1:0] A_WAKE_LVL = 4'h7;
  localparam logic [AW-1:0] A_WAKE_ERR = 4'h8;
  localparam logic [AW-1:0] A_BOOST_SPD = 4'h9;
  localparam logic [AW-1:0] A_BOOST_TIME = 4'hA;
  localparam logic [AW-1:0] A_SLP_DLY = 4'hB;
  localparam logic [AW-1:0] A_WAKE_DLY = 4'hC;
  localparam logic [AW-1:0] A_STATUS = 4'hD;
  localparam logic [AW-1:0] A_COUNT = 4'hE;
  localparam int N_CFG = 13;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] RST_CFG = 16'h0000;
  localparam logic [DW-1:0] RD_ZERO = 16'h0000;
  localparam int SWSEL_IDX_LSB = 0;
  localparam int SWSEL_IDX_W = 4;

  // ----------------------------------------------------------------
  // mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    det_none, det_switch, low_flow_code, speed_condition_code,
    power_condition_code, high_pressure_code, det_multiple
  } psw_det_t;

  typedef enum logic [1:0] {
    wake_feedback, wake_error, wake_pressure, wake_off
  } psw_wake_t;

  typedef enum logic [1:0] {
    src_none, src_ai, src_vai, src_pulse
  } psw_src_t;

  typedef enum logic [1:0] {
    swk_none, swk_di, swk_di_low, swk_cmd
  } psw_swk_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsvd;
    psw_swk_t sw_kind;
    psw_src_t pressure_sensor_source;
    psw_src_t flow_sensor_source;
    psw_src_t loop_feedback_source;
    psw_wake_t wake_mode;
    logic loop_action_invert;
    psw_det_t det_mode;
  } psw_ctrl_t;

  typedef struct packed {
    logic active;
    logic pid_run;
    logic boost_on;
    logic motor_stop;
    logic asleep;
  } psw_motor_t;

  typedef struct packed {
    logic signed [DW-1:0] ai;
    logic signed [DW-1:0] vai;
    logic signed [DW-1:0] pulse;
  } psw_sens_t;

endpackage

//--- bench/psw_motor_model.sv
/*
  Pump motor model: output frequency, power and running flag.
  Assumes registered commands from the sleep/wake sequencer.
*/
`timescale 1ns/1ps
module psw_motor_model
  import psw_pkg::*;
(
  // commands
  input wire psw_motor_t motor_cmd,
  input wire logic [DW-1:0] speed_ref,
  // knobs
  input wire logic spin,
  input wire logic [DW-1:0] run_hz,
  // feedback
  output logic motor_running,
  output logic [DW-1:0] out_freq,
  output logic [DW-1:0] out_power
);
  // ----------------------------------------------------------------
  // motor
  // ----------------------------------------------------------------
  always_comb begin
    if (motor_cmd.boost_on) begin
      out_freq = speed_ref;
    end else if (motor_cmd.pid_run) begin
      out_freq = run_hz;
    end else begin
      out_freq = 16'h0000;
    end
  end
  // power follows speed; crude but monotonic
  assign out_power = out_freq >> 1;
  assign motor_running = spin || (out_freq != 16'h0000);
endmodule

//--- bench/psw_sleep_wake_properties.sv
/*
  Checker of the sequencer command outputs.
  Assumes clk_en high whenever relations are judged.
*/
`timescale 1ns/1ps
module psw_sleep_wake_properties
  import psw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // drive state
  input wire logic chan1_sel,
  input wire logic pid_auto,
  input wire logic run_order,
  input wire logic motor_running,
  // commands
  input wire psw_motor_t motor_cmd,
  input wire logic [DW-1:0] speed_ref
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // frozen cycles would break the one-edge relations
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst || !clk_en);
  chk_boost_ref_zero: assert property (!motor_cmd.boost_on |-> speed_ref == 16'h0000)
    else $error("speed reference outside boost");
  chk_boost_sleep_state: assert property (motor_cmd.boost_on |->
    motor_cmd.asleep && !motor_cmd.pid_run && !motor_cmd.motor_stop)
    else $error("boost state mixed");
  chk_run_not_asleep: assert property (motor_cmd.pid_run |-> !motor_cmd.asleep)
    else $error("regulating while asleep");
  chk_loop_off_idle: assert property (!chan1_sel |=> motor_cmd == 5'h00)
    else $error("active without channel one");
  chk_active_needs_loop: assert property (motor_cmd.active |->
    $past(chan1_sel) && $past(pid_auto) && $past(run_order))
    else $error("active without loop mode");
  chk_wake_to_run: assert property ($fell(motor_cmd.motor_stop) && motor_cmd.active |->
    motor_cmd.pid_run)
    else $error("wake not into regulation");
  chk_boost_then_stop: assert property ($fell(motor_cmd.boost_on) && motor_cmd.active |->
    motor_cmd.motor_stop)
    else $error("boost not followed by stop");
  chk_entry_state: assert property ($rose(motor_cmd.active) |->
    motor_cmd.pid_run || (motor_cmd.motor_stop && !motor_cmd.boost_on))
    else $error("bad entry state");
  chk_running_entry: assert property ($rose(motor_cmd.active) && $past(motor_running) |->
    motor_cmd.pid_run)
    else $error("running entry not regulating");
  cover property ($rose(motor_cmd.boost_on));
  cover property ($fell(motor_cmd.motor_stop) && motor_cmd.pid_run);
  cover property ($rose(motor_cmd.motor_stop) && !$past(motor_cmd.boost_on));
endmodule

bind psw_sleep_wake psw_sleep_wake_properties chk_inst (
  .core_clk(core_clk),
  .nrst(nrst),
  .clk_en(clk_en),
  .chan1_sel(chan1_sel),
  .pid_auto(pid_auto),
  .run_order(run_order),
  .motor_running(motor_running),
  .motor_cmd(motor_cmd),
  .speed_ref(speed_ref)
);

//--- bench/tb_psw_sleep_wake.sv
/*
  Self-checking bench of the sleep/wake sequencer.
  Assumes the motor model on the command side, clk_en held high except for one write in the register test.
*/
`timescale 1ns/1ps
module tb_psw_sleep_wake;
  import psw_pkg::*;
  localparam logic [15:0] DLY = 16'h0004;
  logic core_clk, nrst, clk_en, reg_wr, reg_rd, chan1_sel, pid_auto, run_order;
  logic motor_running, spin;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, out_freq, out_power, speed_ref, run_hz, fb_val;
  logic [5:0] din_pins;
  psw_motor_t motor_cmd;
  psw_sens_t sens;
  int n_errors, samples_checked, cyc;
  assign sens = {fb_val, 16'h7FFF, 16'h7FFF};
  psw_sleep_wake psw_sleep_wake_inst (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan1_sel(chan1_sel), .pid_auto(pid_auto), .run_order(run_order),
    .motor_running(motor_running), .out_freq(out_freq), .out_power(out_power),
    .loop_feedback(fb_val), .loop_setpoint(16'h00C8), .sens(sens), .din_pins(din_pins),
    .motor_cmd(motor_cmd), .speed_ref(speed_ref));
  psw_motor_model psw_motor_model_inst (.motor_cmd(motor_cmd), .speed_ref(speed_ref),
    .spin(spin), .run_hz(run_hz), .motor_running(motor_running), .out_freq(out_freq),
    .out_power(out_power));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic chk1(logic s, logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask
  task automatic wr(logic [AW-1:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [AW-1:0] a, logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic go(logic v);
    @(posedge core_clk);
    chan1_sel <= v;
    pid_auto <= v;
    run_order <= v;
  endtask
  task automatic step(int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  function automatic logic pick(int k);
    return k == 0 ? motor_cmd.pid_run : k == 1 ? motor_cmd.motor_stop : motor_cmd.boost_on;
  endfunction
  task automatic wt(int k, int n);
    int i;
    i = 0;
    while (pick(k) !== 1'b1 && i < n) begin
      step(1);
      i++;
    end
  endtask
  task automatic stop();
    go(1'b0);
    step(2);
    chk({11'h000, motor_cmd}, 16'h0000);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(A_CTRL, RST_CFG);
    wr(A_SLP_DLY, DLY);
    rd(A_SLP_DLY, RD_ZERO);
    wr(A_CTRL, 16'h0040);
    wr(A_SLP_DLY, DLY);
    rd(A_SLP_DLY, DLY);
    clk_en <= 1'b0;
    wr(A_SLP_DLY, 16'h0007);
    clk_en <= 1'b1;
    rd(A_SLP_DLY, DLY);
    rd(4'hF, RD_ZERO);
    $display("register test done");
  endtask
  task automatic t_sleep(logic [15:0] c, logic [15:0] l, logic [15:0] bt, logic e);
    int n;
    wr(A_CTRL, c);
    wr(A_SWSEL, 16'h0000);
    wr(A_CMD, 16'h0001);
    wr(A_SLP_FLOW, 16'h0032);
    wr(A_SLP_PRES, 16'h0005);
    wr(A_SLP_SPEED, l);
    wr(A_SLP_POWER, l);
    wr(A_BOOST_SPD, 16'h0123);
    wr(A_BOOST_TIME, bt);
    wr(A_SLP_DLY, DLY);
    fb_val <= 16'h000A;
    spin <= 1'b1;
    go(1'b1);
    step(1);
    wt(0, 8);
    chk1(motor_cmd.pid_run, 1'b1);
    chk1(motor_cmd.active, 1'b1);
    step(DLY);
    chk1(motor_cmd.asleep, 1'b0);
    if (bt != 16'h0000) begin
      wt(2, 6);
      chk(speed_ref, 16'h0123);
      n = 0;
      while (motor_cmd.boost_on === 1'b1 && n < 9) begin
        step(1);
        n++;
      end
      chk(n[15:0], bt);
    end
    wt(1, 8);
    chk1(motor_cmd.motor_stop, e);
    chk1(motor_cmd.asleep, e);
    chk1(motor_cmd.boost_on, 1'b0);
    stop();
    $display("sleep case %h done", c);
  endtask
  task automatic t_wake(logic [15:0] c, logic [15:0] vf, logic [15:0] vt);
    wr(A_CTRL, c);
    wr(A_WAKE_LVL, 16'h0064);
    wr(A_WAKE_ERR, 16'h000A);
    wr(A_WAKE_DLY, DLY);
    fb_val <= vf;
    spin <= 1'b0;
    go(1'b1);
    step(1);
    wt(1, 8);
    chk1(motor_cmd.motor_stop, 1'b1);
    chk1(motor_cmd.pid_run, 1'b0);
    @(posedge core_clk);
    fb_val <= vt;
    step(DLY);
    chk1(motor_cmd.pid_run, 1'b0);
    wt(0, 8);
    chk1(motor_cmd.pid_run, 1'b1);
    stop();
    $display("wake case %h done", c);
  endtask
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    {reg_wr, reg_rd, chan1_sel, pid_auto, run_order, spin} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    run_hz = 16'h0020;
    fb_val = 16'h0000;
    din_pins = 6'h01;
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_sleep(16'h3071, 16'h0000, 16'h0000, 1'b1);
    t_sleep(16'h1071, 16'h0000, 16'h0000, 1'b1);
    t_sleep(16'h2071, 16'h0000, 16'h0000, 1'b0);
    t_sleep(16'h0071, 16'h0000, 16'h0000, 1'b0);
    t_sleep(16'h0172, 16'h0000, 16'h0000, 1'b1);
    t_sleep(16'h0272, 16'h0000, 16'h0000, 1'b0);
    t_sleep(16'h0372, 16'h0000, 16'h0000, 1'b0);
    t_sleep(16'h0073, 16'h0040, 16'h0000, 1'b1);
    t_sleep(16'h0073, 16'h0020, 16'h0000, 1'b0);
    t_sleep(16'h0074, 16'h0040, 16'h0000, 1'b1);
    t_sleep(16'h0475, 16'h0000, 16'h0000, 1'b1);
    t_sleep(16'h3076, 16'h0000, 16'h0000, 1'b1);
    t_sleep(16'h0070, 16'h0040, 16'h0000, 1'b0);
    t_sleep(16'h0073, 16'h0040, 16'h0003, 1'b1);
    t_wake(16'h0040, 16'h0096, 16'h0032);
    t_wake(16'h0048, 16'h0032, 16'h0096);
    t_wake(16'h0050, 16'h00C3, 16'h00B4);
    t_wake(16'h0058, 16'h00CD, 16'h00DC);
    t_wake(16'h0460, 16'h0096, 16'h0032);
    finish_test();
  end
endmodule
